// ### sup_defines.svh
`ifndef SUP_DEFINES_SVH
`define SUP_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define HOLD_TIME_MS 250
`define HOLD_CYCLES ((`HOLD_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define WD_SHORT_MS 200
`define WD_MID_MS 600
`define WD_LONG_MS 1400
`define WD_SHORT_CYCLES ((`WD_SHORT_MS * 1000000) / `CLK_PERIOD_NS)
`define WD_MID_CYCLES ((`WD_MID_MS * 1000000) / `CLK_PERIOD_NS)
`define WD_LONG_CYCLES ((`WD_LONG_MS * 1000000) / `CLK_PERIOD_NS)
// ----------------------------------------
// Field layout
// ----------------------------------------
`define CNT_W 32
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define WD_CODE_SHORT 2'h0
`define WD_CODE_MID 2'h1
`define WD_CODE_LONG 2'h2
`define WD_CODE_OFF 2'h3
// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define SYNC_W 6
`define SYNC_SUPPLY 5
`define SYNC_SEL 4
`define SYNC_SCK 3
`define SYNC_SI 2
`define SYNC_WP 1
`define SYNC_BUSY 0
`endif

// ### sup_pkg.sv
package sup_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] wd_sel_t;
	typedef enum logic [1:0] {
		PWR_STANDBY,
		PWR_ACTIVE,
		PWR_WRITE_BUSY
	} pwr_state_e;
endpackage : sup_pkg

// ### byte_buf2.sv
`timescale 1ns/1ps
module byte_buf2 (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire sup_pkg::byte_t in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output sup_pkg::byte_t out_data_o
);
	import sup_pkg::*;
	byte_t mem_r [2];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] count_r;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (count_r != 2'h2);
	assign out_valid_o = (count_r != 2'h0);
	assign out_data_o = mem_r[rd_ptr_r];
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || flush_i) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_data_i;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : byte_buf2

// ### supervisor_spi_pin_logic.sv
`timescale 1ns/1ps
`include "sup_defines.svh"
// Notes on behaviour
// (RQ1) Select high deselects device; serial output floats.
// (RQ2) Select high and no write busy gives standby; select low gives active.
// (RQ3) After power-up nothing is accepted until a select falling edge.
// (RQ4) Each select falling edge restarts the watchdog.
// (RQ5) No falling edge within the period asserts the reset output.
// (RQ6) Watchdog trips only when enabled, select stuck high or low.
// (RQ7) Read data is driven and changes on serial clock falling edges.
// (RQ8) Input bits sampled on rising serial clock edges, MSB first.
// (RQ9) Write protect low refuses nonvolatile writes.
// (RQ10) Open-drain reset asserts under sense level, releases after 250 ms above.
// (RQ11) Reset active at power-up and held 250 ms after supply settles.
// (RQ12) Watchdog period chosen by two retained period bits.
// (RQ13) While reset is asserted the serial interface is blocked.
// (RQ14) Hold counter restarts if supply dips again mid-hold.
module supervisor_spi_pin_logic #(
	parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES,
	parameter int unsigned WD_SHORT_CYCLES = `WD_SHORT_CYCLES,
	parameter int unsigned WD_MID_CYCLES = `WD_MID_CYCLES,
	parameter int unsigned WD_LONG_CYCLES = `WD_LONG_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Supply monitor
	input wire logic supply_ok_i,
	// Serial pins
	input wire logic select_and_watchdog_input_i,
	input wire logic sck_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	input wire logic write_protect_n_i,
	// Retained period bits
	input wire logic watchdog_period_bit_hi_i,
	input wire logic watchdog_period_bit_lo_i,
	// Write cycle status
	input wire logic nv_write_busy_i,
	// Reset output, open drain
	output logic reset_n_o,
	output logic reset_oe_o,
	// Received bytes
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output sup_pkg::byte_t rx_data_o,
	output logic rx_write_allowed_o,
	// Read data to shift out
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire sup_pkg::byte_t tx_data_i,
	// Power state
	output sup_pkg::pwr_state_e pwr_state_o,
	output logic armed_o
);
	import sup_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Pins are async to ref_clk; two flops each before any use
	localparam int NSYNC = `SYNC_W;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	assign raw_in = {supply_ok_i, select_and_watchdog_input_i, sck_i, si_i,
		write_protect_n_i, nv_write_busy_i};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk_i) begin
				// Select idles high, so its lane resets high: no false edge
				if (!rst_n_i) begin
					sync1_r[gi] <= (gi == `SYNC_SEL) ? 1'b1 : 1'b0;
					sync2_r[gi] <= (gi == `SYNC_SEL) ? 1'b1 : 1'b0;
				end else begin
					sync1_r[gi] <= raw_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate
	wire supply_s = sync2_r[`SYNC_SUPPLY];
	wire sel_s = sync2_r[`SYNC_SEL];
	wire sck_s = sync2_r[`SYNC_SCK];
	wire si_s = sync2_r[`SYNC_SI];
	wire wp_n_s = sync2_r[`SYNC_WP];
	wire busy_s = sync2_r[`SYNC_BUSY];
	// SCK idle level depends on mode; the link stays shut through the hold

	logic sel_d_r;
	logic sck_d_r;
	wire sel_fall = sel_d_r && !sel_s;
	wire sck_rise = !sck_d_r && sck_s;
	wire sck_fall = sck_d_r && !sck_s;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sel_d_r <= 1'b1;
			sck_d_r <= 1'b0;
		end else begin
			sel_d_r <= sel_s;
			sck_d_r <= sck_s;
		end
	end

	// ----------------------------------------
	// Supply hold and reset output
	// ----------------------------------------
	logic [`CNT_W-1:0] hold_cnt_r;
	logic hold_done_r;
	logic wd_trip_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			hold_cnt_r <= '0;
			hold_done_r <= 1'b0;
		end else if (!supply_s || wd_trip_r) begin
			hold_cnt_r <= '0; // [RQ14]
			hold_done_r <= 1'b0; // [RQ10]
		end else if (!hold_done_r) begin
			if (hold_cnt_r == `CNT_W'(HOLD_CYCLES - 1))
				hold_done_r <= 1'b1; // [RQ11]
			else
				hold_cnt_r <= hold_cnt_r + `CNT_W'(1);
		end
	end
	// Drain only; level low when enabled
	wire reset_active = !hold_done_r;
	assign reset_n_o = 1'b0;
	assign reset_oe_o = reset_active; // [RQ10] [RQ11]

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	wd_sel_t wd_code;
	logic [`CNT_W-1:0] wd_limit;
	logic [`CNT_W-1:0] wd_cnt_r;
	// Counts at either select level, so a stuck-low host trips as well
	assign wd_code = {watchdog_period_bit_hi_i, watchdog_period_bit_lo_i};
	wire wd_enabled = (wd_code != `WD_CODE_OFF); // [RQ6]
	assign wd_limit = (wd_code == `WD_CODE_SHORT) ? `CNT_W'(WD_SHORT_CYCLES) :
		(wd_code == `WD_CODE_MID) ? `CNT_W'(WD_MID_CYCLES) :
		`CNT_W'(WD_LONG_CYCLES); // [RQ12]
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || reset_active || !wd_enabled || sel_fall) begin
			wd_cnt_r <= '0; // [RQ4]
			wd_trip_r <= 1'b0;
		end else if (wd_cnt_r == wd_limit - `CNT_W'(1)) begin
			wd_trip_r <= 1'b1; // [RQ5] [RQ6]
			wd_cnt_r <= '0;
		end else begin
			wd_cnt_r <= wd_cnt_r + `CNT_W'(1);
			wd_trip_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Select, arming and power state
	// ----------------------------------------
	// Armed only by a falling edge seen while out of reset
	logic armed_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || reset_active)
			armed_r <= 1'b0; // [RQ13]
		else if (sel_fall)
			armed_r <= 1'b1; // [RQ3]
	end
	assign armed_o = armed_r;
	wire link_on = armed_r && !sel_s && !reset_active; // [RQ13]
	assign pwr_state_o = !sel_s ? PWR_ACTIVE :
		busy_s ? PWR_WRITE_BUSY : PWR_STANDBY; // [RQ2]

	// ----------------------------------------
	// Receive shifter
	// ----------------------------------------
	logic [`BIT_CNT_W-1:0] rx_bit_r;
	byte_t rx_sh_r;
	logic rx_push_r;
	byte_t rx_word_r;
	logic rx_ready_buf;
	wire rx_done = link_on && sck_rise && (rx_bit_r == `BIT_LAST);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !link_on) begin
			rx_bit_r <= '0;
		end else if (sck_rise) begin
			rx_sh_r <= {rx_sh_r[`BYTE_W-2:0], si_s}; // [RQ8]
			rx_bit_r <= rx_bit_r + `BIT_CNT_W'(1);
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rx_done)
			rx_word_r <= {rx_sh_r[`BYTE_W-2:0], si_s}; // [RQ8]
	end
	// A finished word outlives deselect; only reset drops it. New word wins a clash.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || reset_active)
			rx_push_r <= 1'b0; // [RQ13]
		else if (rx_done)
			rx_push_r <= 1'b1;
		else if (rx_ready_buf)
			rx_push_r <= 1'b0;
	end
	// A stall of more than one pending word overwrites; buffer depth covers it
	byte_buf2 byte_buf2_inst (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(reset_active),
		.in_valid_i(rx_push_r),
		.in_ready_o(rx_ready_buf),
		.in_data_i(rx_word_r),
		.out_valid_o(rx_valid_o),
		.out_ready_i(rx_ready_i),
		.out_data_o(rx_data_o)
	);
	assign rx_write_allowed_o = wp_n_s; // [RQ9]

	// ----------------------------------------
	// Transmit shifter
	// ----------------------------------------
	logic [`BIT_CNT_W-1:0] tx_bit_r;
	byte_t tx_sh_r;
	logic tx_loaded_r;
	logic so_r;
	logic so_en_r;
	assign tx_ready_o = link_on && !tx_loaded_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !link_on) begin
			tx_bit_r <= '0;
			tx_loaded_r <= 1'b0;
			so_r <= 1'b0;
			so_en_r <= 1'b0; // [RQ1]
		end else begin
			if (tx_valid_i && tx_ready_o) begin
				tx_sh_r <= tx_data_i;
				tx_loaded_r <= 1'b1;
			end
			if (sck_fall && tx_loaded_r) begin
				so_r <= tx_sh_r[`BYTE_W-1]; // [RQ7]
				so_en_r <= 1'b1;
				tx_sh_r <= {tx_sh_r[`BYTE_W-2:0], 1'b0};
				tx_bit_r <= tx_bit_r + `BIT_CNT_W'(1);
				if (tx_bit_r == `BIT_LAST)
					tx_loaded_r <= 1'b0;
			end
		end
	end
	assign so_o = so_r;
	// Gated by link state so a reset in mid-read floats the pin at once
	assign so_oe_o = so_en_r && link_on; // [RQ1] [RQ13]

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_hiz_when_deselected;
		@(posedge ref_clk_i) disable iff (!rst_n_i) sel_s |-> !so_oe_o;
	endproperty
	a_hiz_when_deselected: assert property (p_hiz_when_deselected) // [RQ1]
		else $error("serial output driven while deselected");
	property p_power_state;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(sel_s && !busy_s) |-> pwr_state_o == PWR_STANDBY;
	endproperty
	a_power_state: assert property (p_power_state) else $error("standby expected"); // [RQ2]
	property p_arm_edge;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(armed_r) |-> $past(sel_fall);
	endproperty
	a_arm_edge: assert property (p_arm_edge) else $error("armed without edge"); // [RQ3]
	property p_wd_restart;
		@(posedge ref_clk_i) disable iff (!rst_n_i) sel_fall |=> wd_cnt_r == '0;
	endproperty
	a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted"); // [RQ4]
	property p_wd_reset;
		@(posedge ref_clk_i) disable iff (!rst_n_i) wd_trip_r |=> reset_oe_o;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("trip without reset"); // [RQ5]
	property p_wd_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !wd_enabled |=> !wd_trip_r;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("disabled watchdog tripped"); // [RQ6]
	property p_so_fall;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(link_on && $changed(so_r)) |-> $past(sck_fall);
	endproperty
	a_so_fall: assert property (p_so_fall) else $error("output changed off fall"); // [RQ7]
	property p_low_supply;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !supply_s |=> reset_oe_o [*2];
	endproperty
	a_low_supply: assert property (p_low_supply) else $error("reset not held low"); // [RQ10]
	property p_hold_restart;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!supply_s |=> hold_cnt_r == '0 && !hold_done_r;
	endproperty
	a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted"); // [RQ14]
	property p_blocked;
		@(posedge ref_clk_i) disable iff (!rst_n_i) reset_active |-> !tx_ready_o && !so_oe_o;
	endproperty
	a_blocked: assert property (p_blocked) else $error("link open during reset"); // [RQ13]
	property p_wp;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !wp_n_s |-> !rx_write_allowed_o;
	endproperty
	a_wp: assert property (p_wp) else $error("write allowed while protected"); // [RQ9]
	c_wd_trip: cover property (@(posedge ref_clk_i) wd_trip_r);
	c_rx_byte: cover property (@(posedge ref_clk_i) rx_valid_o && rx_ready_i);
	c_release: cover property (@(posedge ref_clk_i) $fell(reset_oe_o));
endmodule : supervisor_spi_pin_logic

// ### host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model (
	// Serial pins
	output logic select_o,
	output logic sck_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_i
);
	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	initial begin
		select_o = 1'b1;
		sck_o = 1'b1;
		si_o = 1'b0;
	end
	// ----------------------------------------
	// Frames
	// ----------------------------------------
	// Every frame starts with a select fall: arms and restarts the watchdog
	task automatic frame_open();
		#3 select_o = 1'b0;
		#80;
	endtask : frame_open
	// Clock idles high, SI set after the fall, MSB first
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck_o = 1'b0;
			si_o = tx[i];
			#80 sck_o = 1'b1;
			rx[i] = so_oe_i ? so_i : 1'bx;
			#80;
		end
	endtask : shift_byte
	// Released data line shows the inverse of its last bit, not a stale copy
	task automatic frame_close();
		select_o = 1'b1;
		si_o = ~si_o;
		#73;
	endtask : frame_close
endmodule : host_spi_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
	import sup_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int HOLD = 200;
	typedef struct {logic wp; byte_t tx; byte_t rx;} row_s;
	row_s rows [3] = '{'{1'b1, 8'h3C, 8'hA5}, '{1'b0, 8'hC3, 8'h5A}, '{1'b1, 8'h01, 8'h80}};
	logic ref_clk_i, rst_n_i, supply_ok_i, write_protect_n_i, wd_hi, wd_lo, busy;
	logic select, sck, si, so_o, so_oe_o, reset_n_o, reset_oe_o, rx_valid_o, rx_ready_i;
	logic rx_write_allowed_o, tx_valid_i, tx_ready_o, armed_o;
	byte_t rx_data_o, tx_data_i, got, b;
	pwr_state_e pwr_state_o;
	byte_t rx_q [$];
	int n_mismatch = 0;
	int compares = 0;
	int n;
	// Open drain with pull-up
	wire reset_line = reset_oe_o ? reset_n_o : 1'b1;
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	supervisor_spi_pin_logic #(.HOLD_CYCLES(HOLD), .WD_SHORT_CYCLES(400), .WD_MID_CYCLES(600),
		.WD_LONG_CYCLES(800)) supervisor_spi_pin_logic_inst (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i), .select_and_watchdog_input_i(select),
		.sck_i(sck), .si_i(si), .so_o(so_o), .so_oe_o(so_oe_o),
		.write_protect_n_i(write_protect_n_i), .watchdog_period_bit_hi_i(wd_hi),
		.watchdog_period_bit_lo_i(wd_lo), .nv_write_busy_i(busy), .reset_n_o(reset_n_o),
		.reset_oe_o(reset_oe_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
		.rx_data_o(rx_data_o), .rx_write_allowed_o(rx_write_allowed_o), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .pwr_state_o(pwr_state_o),
		.armed_o(armed_o));
	host_spi_model host_spi_model_inst (.select_o(select), .sck_o(sck), .si_o(si),
		.so_i(so_o), .so_oe_i(so_oe_o));
	always @(posedge ref_clk_i) begin
		if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) rx_q.push_back(rx_data_o);
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	// Bounded wait for the reset output, counts edges spent
	task automatic wait_oe(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (reset_oe_o !== lvl && cnt < lim) begin
			@(negedge ref_clk_i);
			cnt++;
		end
		if (reset_oe_o !== lvl) begin
			n_mismatch++;
			results();
		end
	endtask : wait_oe
	task automatic pop_rx(output byte_t v);
		for (int i = 0; i < 50 && rx_q.size() == 0; i++) @(negedge ref_clk_i);
		if (rx_q.size() == 0) begin
			n_mismatch++;
			results();
		end
		v = rx_q.pop_front();
	endtask : pop_rx
	task automatic xfer(input byte_t v);
		@(posedge ref_clk_i);
		host_spi_model_inst.frame_open();
		host_spi_model_inst.shift_byte(v, got);
		host_spi_model_inst.frame_close();
	endtask : xfer
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{rst_n_i, supply_ok_i, write_protect_n_i, wd_hi, wd_lo, busy} = 6'b011110;
		{rx_ready_i, tx_valid_i, tx_data_i} = {2'b11, 8'h00};
		repeat (6) @(negedge ref_clk_i);
		check("reset line", reset_line, 1'b0);
		check("so enable", so_oe_o, 1'b0);
		check("rx valid", rx_valid_o, 1'b0);
		@(posedge ref_clk_i) rst_n_i <= 1'b1;
		wait_oe(1'b0, 400, n);
		check("hold", n >= HOLD - 2 && n <= HOLD + 10, 1'b1);
		check("armed", armed_o, 1'b0);
		check("pwr", pwr_state_o, PWR_STANDBY);
		for (int k = 0; k < 3; k++) begin
			@(posedge ref_clk_i);
			write_protect_n_i <= rows[k].wp;
			tx_data_i <= rows[k].tx;
			host_spi_model_inst.frame_open();
			check("pwr", pwr_state_o, PWR_ACTIVE);
			check("armed", armed_o, 1'b1);
			host_spi_model_inst.shift_byte(rows[k].rx, got);
			host_spi_model_inst.frame_close();
			check("so enable", so_oe_o, 1'b0);
			pop_rx(b);
			check("rx byte", b, rows[k].rx);
			check("so byte", got, rows[k].tx);
			check("write allowed", rx_write_allowed_o, rows[k].wp);
		end
		@(posedge ref_clk_i) busy <= 1'b1;
		repeat (4) @(negedge ref_clk_i);
		check("pwr", pwr_state_o, PWR_WRITE_BUSY);
		@(posedge ref_clk_i) busy <= 1'b0;
		// Open link with nothing queued: ready for a read byte
		tx_valid_i <= 1'b0;
		host_spi_model_inst.frame_open();
		check("tx ready", tx_ready_o, 1'b1);
		host_spi_model_inst.frame_close();
		// Stalled receiver: both words survive in order
		@(posedge ref_clk_i) rx_ready_i <= 1'b0;
		xfer(8'h11);
		xfer(8'h22);
		check("rx valid", rx_valid_o, 1'b1);
		@(posedge ref_clk_i) rx_ready_i <= 1'b1;
		pop_rx(b);
		check("rx first", b, 8'h11);
		pop_rx(b);
		check("rx second", b, 8'h22);
		// Short period, kept alive, then left stuck high
		@(posedge ref_clk_i) {wd_hi, wd_lo} <= 2'h0;
		for (int k = 0; k < 5; k++) begin
			repeat (150) @(posedge ref_clk_i);
			host_spi_model_inst.frame_open();
			host_spi_model_inst.frame_close();
		end
		check("kept alive", reset_oe_o, 1'b0);
		wait_oe(1'b1, 500, n);
		check("trip high", n >= 355 && n <= 400, 1'b1);
		// Hold blocks the link even with select low
		@(posedge ref_clk_i);
		host_spi_model_inst.frame_open();
		check("tx ready", tx_ready_o, 1'b0);
		host_spi_model_inst.shift_byte(8'h77, got);
		check("so enable", so_oe_o, 1'b0);
		host_spi_model_inst.frame_close();
		check("blocked", 8'(rx_q.size()), 8'h00);
		wait_oe(1'b0, 400, n);
		// Middle period, left stuck low
		@(posedge ref_clk_i) {wd_hi, wd_lo} <= 2'h1;
		host_spi_model_inst.frame_open();
		wait_oe(1'b1, 700, n);
		check("trip low", n >= 575 && n <= 600, 1'b1);
		host_spi_model_inst.frame_close();
		@(posedge ref_clk_i) {wd_hi, wd_lo} <= 2'h3;
		wait_oe(1'b0, 400, n);
		repeat (900) @(negedge ref_clk_i);
		check("disabled", reset_oe_o, 1'b0);
		// Supply dip, then a second dip in mid-hold
		@(posedge ref_clk_i) supply_ok_i <= 1'b0;
		repeat (4) @(negedge ref_clk_i);
		check("low supply", reset_oe_o, 1'b1);
		@(posedge ref_clk_i) supply_ok_i <= 1'b1;
		repeat (100) @(negedge ref_clk_i);
		@(posedge ref_clk_i) supply_ok_i <= 1'b0;
		repeat (4) @(negedge ref_clk_i);
		@(posedge ref_clk_i) supply_ok_i <= 1'b1;
		wait_oe(1'b0, 400, n);
		check("rehold", n >= HOLD - 4 && n <= HOLD + 10, 1'b1);
		results();
	end
endmodule : testbench
